// [core/bcc_config_regs.sv]
// write-side control register bank of a dual-channel bias controller
// assumes the serial decoder gives a one-cycle write strobe with selector and 16-bit data
`timescale 1ns/100ps
`default_nettype none
`include "bcc_regs.svh"
module bcc_config_regs
  import bcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register writes from the serial decoder
  input  wire logic        regWrite,
  input  wire logic [7:0]  regSel,
  input  wire logic [15:0] regData,
  input  wire logic        cmdSeen,
  // register read of alarm configuration
  output logic      [7:0]  alarmReadback,
  // fine DAC outputs
  output logic      [9:0]  fineOut1,
  output logic      [9:0]  fineOut2,
  output logic             fineCorr1,
  output logic             fineCorr2,
  // coarse wiper outputs
  output logic      [7:0]  upperWiper1,
  output logic      [7:0]  upperWiper2,
  output logic      [7:0]  lowerWiper1,
  output logic      [7:0]  lowerWiper2,
  output logic      [3:0]  autocalStart,
  // alarm configuration
  output bcc_alarm_t       alarmCfg,
  // scan setup
  output logic             repeatScanEnable,
  output logic      [6:0]  scanSelect,
  output logic             scanWritten,
  // queue flush
  output logic             resultQueueFlush,
  // shutdown
  output bcc_shut_t        shutCtl
);
  // selector decode used for every register
  function automatic logic hit(input logic [7:0] sel, input logic [7:0] addr);
    hit = (sel == addr);
  endfunction

  wire wrFinePt1  = regWrite & hit(regSel, `BCC_ADDR_FINE_PT1);
  wire wrFinePt2  = regWrite & hit(regSel, `BCC_ADDR_FINE_PT2);
  wire wrFinePl1  = regWrite & hit(regSel, `BCC_ADDR_FINE_PL1);
  wire wrFinePl2  = regWrite & hit(regSel, `BCC_ADDR_FINE_PL2);
  wire wrFineCo1  = regWrite & hit(regSel, `BCC_ADDR_FINE_CO1);
  wire wrFineCo2  = regWrite & hit(regSel, `BCC_ADDR_FINE_CO2);
  wire wrUpw1     = regWrite & hit(regSel, `BCC_ADDR_UPW1);
  wire wrUpw2     = regWrite & hit(regSel, `BCC_ADDR_UPW2);
  wire wrLow1     = regWrite & hit(regSel, `BCC_ADDR_LOW1);
  wire wrLow2     = regWrite & hit(regSel, `BCC_ADDR_LOW2);
  wire wrLoad     = regWrite & hit(regSel, `BCC_ADDR_LOAD);
  wire wrAlarm    = regWrite & hit(regSel, `BCC_ADDR_ALARM);
  wire wrScan     = regWrite & hit(regSel, `BCC_ADDR_SCAN);
  wire wrClear    = regWrite & hit(regSel, `BCC_ADDR_CLEAR);
  wire wrShut     = regWrite & hit(regSel, `BCC_ADDR_SHUT);

  // load strobe exists only for the write cycle, so nothing stays pending
  wire [5:0] loadBits = wrLoad ? regData[5:0] : 6'h00;

  // full reset sequencer state
  bcc_rst_state_t rstState_q;
  bcc_rst_state_t rstState_d;
  wire armPattern  = ~regData[`BCC_CL_FIRE] & regData[`BCC_CL_ARM];
  wire firePattern = regData[`BCC_CL_FIRE] & ~regData[`BCC_CL_ARM];
  wire global_reset_fire   = wrClear & firePattern & (rstState_q == BCC_ARMED);

  // arm must be the clear write right before fire; any clear write but an arm disarms
  always_comb begin
    rstState_d = rstState_q;
    case (rstState_q)
      BCC_IDLE: begin
        if (wrClear && armPattern) begin
          rstState_d = BCC_ARMED;
        end
      end
      BCC_ARMED: begin
        // a repeated arm write keeps the sequencer armed
        if (wrClear && !armPattern) begin
          rstState_d = BCC_IDLE;
        end
      end
      default: begin
        rstState_d = BCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstState_q <= BCC_IDLE;
    end else begin
      rstState_q <= rstState_d;
    end
  end

  // clear bits act only on the write cycle; full reset covers every DAC
  wire [5:0] clrBits = (wrClear ? regData[5:0] : 6'h00) | {6{global_reset_fire}};
  wire flushNow      = (wrClear & regData[`BCC_CL_FLUSH]) | global_reset_fire;

  // fine channels, codes take the low ten bits only
  bcc_fine_chan uFine1 (
    .clk           (clk),
    .arst_n        (arst_n),
    .wrPlain       (wrFinePl1),
    .wrCorrected   (wrFineCo1),
    .wrPassthrough (wrFinePt1),
    .wrCode        (regData[9:0]),
    .loadFine      (loadBits[`BCC_LD_FINE_INPUT_PLAIN_CH1]),
    .clearFine     (clrBits[`BCC_CL_FINE_INPUT_PLAIN_CH1]),
    .fineInput     (),
    .fineOutput    (fineOut1),
    .corrLast      (fineCorr1)
  );

  bcc_fine_chan uFine2 (
    .clk           (clk),
    .arst_n        (arst_n),
    .wrPlain       (wrFinePl2),
    .wrCorrected   (wrFineCo2),
    .wrPassthrough (wrFinePt2),
    .wrCode        (regData[9:0]),
    .loadFine      (loadBits[`BCC_LD_FINE_INPUT_PLAIN_CH2]),
    .clearFine     (clrBits[`BCC_CL_FINE_INPUT_PLAIN_CH2]),
    .fineInput     (),
    .fineOutput    (fineOut2),
    .corrLast      (fineCorr2)
  );

  // wipers: autocal flag in bit 15 folded into input bit 8
  wire [8:0] wiperWord = {regData[`BCC_CAL_FLAG], regData[7:0]};

  bcc_wiper_chan uUpw1 (
    .clk         (clk),
    .arst_n      (arst_n),
    .wrInput     (wrUpw1),
    .wrData      (wiperWord),
    .loadWiper   (loadBits[`BCC_LD_UPW1]),
    .clearWiper  (clrBits[`BCC_CL_UPW1]),
    .wiperOutput (upperWiper1),
    .calStart    (autocalStart[0])
  );

  bcc_wiper_chan uLow1 (
    .clk         (clk),
    .arst_n      (arst_n),
    .wrInput     (wrLow1),
    .wrData      (wiperWord),
    .loadWiper   (loadBits[`BCC_LD_LOW1]),
    .clearWiper  (clrBits[`BCC_CL_LOW1]),
    .wiperOutput (lowerWiper1),
    .calStart    (autocalStart[1])
  );

  bcc_wiper_chan uUpw2 (
    .clk         (clk),
    .arst_n      (arst_n),
    .wrInput     (wrUpw2),
    .wrData      (wiperWord),
    .loadWiper   (loadBits[`BCC_LD_UPW2]),
    .clearWiper  (clrBits[`BCC_CL_UPW2]),
    .wiperOutput (upperWiper2),
    .calStart    (autocalStart[2])
  );

  bcc_wiper_chan uLow2 (
    .clk         (clk),
    .arst_n      (arst_n),
    .wrInput     (wrLow2),
    .wrData      (wiperWord),
    .loadWiper   (loadBits[`BCC_LD_LOW2]),
    .clearWiper  (clrBits[`BCC_CL_LOW2]),
    .wiperOutput (lowerWiper2),
    .calStart    (autocalStart[3])
  );

  // alarm configuration, bits 15..8 dropped
  logic [7:0] alarm_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_q <= `BCC_ALARM_RST;
    end else if (wrAlarm) begin
      alarm_q <= regData[7:0];
    end
  end
  assign alarmCfg      = bcc_alarm_t'(alarm_q);
  assign alarmReadback = alarm_q;

  // scan control; reserved bits 11..8 are the host's to keep zero and are not stored
  logic [7:0] scan_q;
  logic       scanPulse_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_q      <= `BCC_SCAN_RST;
      scanPulse_q <= 1'b0;
    end else begin
      scanPulse_q <= wrScan;
      if (wrScan) begin
        scan_q <= regData[7:0];
      end
    end
  end
  assign repeatScanEnable = scan_q[7];
  assign scanSelect       = scan_q[6:0];
  assign scanWritten      = scanPulse_q;

  // queue flush pulse registered so the output comes from a flip-flop
  logic flush_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= flushNow;
    end
  end
  assign resultQueueFlush = flush_q;

  // shutdown: a write while globally down only writes the global bit, others keep data
  logic [4:0] shut_q;
  logic [4:0] shut_d;
  wire        globalDown = shut_q[4];
  always_comb begin
    shut_d = shut_q;
    if (global_reset_fire) begin
      shut_d = `BCC_SHUT_RST;
    end else if (wrShut && globalDown) begin
      shut_d[4] = regData[`BCC_SH_GLOBAL];
    end else if (wrShut) begin
      shut_d = {regData[`BCC_SH_GLOBAL], regData[`BCC_SH_REF],
                regData[`BCC_SH_OSC], regData[`BCC_SH_CONV2],
                regData[`BCC_SH_CONV1]};
    end else if (cmdSeen) begin
      shut_d[2] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shut_q <= `BCC_SHUT_RST;
    end else begin
      shut_q <= shut_d;
    end
  end
  assign shutCtl = bcc_shut_t'(shut_q);
endmodule
`default_nettype wire

// [core/bcc_fine_chan.sv]
// one fine DAC channel: plain, corrected and passthrough inputs plus output register
// assumes one-cycle write strobes from the register bank
`timescale 1ns/100ps
`default_nettype none
`include "bcc_regs.svh"
module bcc_fine_chan
  import bcc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // writes
  input  wire logic       wrPlain,
  input  wire logic       wrCorrected,
  input  wire logic       wrPassthrough,
  input  wire logic [9:0] wrCode,
  input  wire logic       loadFine,
  input  wire logic       clearFine,
  // state
  output logic      [9:0] fineInput,
  output logic      [9:0] fineOutput,
  output logic            corrLast
);
  logic [9:0] input_q;
  logic [9:0] output_q;
  logic       corr_q;

  // clear beats a simultaneous load so the channel reaches power-on contents
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_q  <= `BCC_FINE_RST;
      output_q <= `BCC_FINE_RST;
      corr_q   <= 1'b0;
    end else if (clearFine) begin
      input_q  <= `BCC_FINE_RST;
      output_q <= `BCC_FINE_RST;
      corr_q   <= 1'b0;
    end else begin
      if (wrPlain || wrCorrected || wrPassthrough) begin
        input_q <= wrCode;
        corr_q  <= wrCorrected;
      end
      if (wrPassthrough) begin
        output_q <= wrCode;
      end else if (loadFine) begin
        output_q <= input_q;
      end
    end
  end

  assign fineInput  = input_q;
  assign fineOutput = output_q;
  assign corrLast   = corr_q;
endmodule
`default_nettype wire

// [core/bcc_wiper_chan.sv]
// one coarse wiper: input register with autocal flag and output register
// assumes one-cycle write strobes from the register bank
`timescale 1ns/100ps
`default_nettype none
`include "bcc_regs.svh"
module bcc_wiper_chan
  import bcc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // writes
  input  wire logic       wrInput,
  input  wire logic [8:0] wrData,
  input  wire logic       loadWiper,
  input  wire logic       clearWiper,
  // state
  output logic      [7:0] wiperOutput,
  output logic            calStart
);
  logic [8:0] input_q;
  logic [7:0] output_q;
  logic       cal_q;

  // flag sits in bit 8 of the input register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_q  <= `BCC_WIPER_RST;
      output_q <= 8'h00;
      cal_q    <= 1'b0;
    end else if (clearWiper) begin
      input_q  <= `BCC_WIPER_RST;
      output_q <= 8'h00;
      cal_q    <= 1'b0;
    end else begin
      if (wrInput) begin
        input_q <= wrData;
      end
      output_q <= loadWiper ? input_q[7:0] : output_q;
      cal_q    <= loadWiper & input_q[8];
    end
  end

  assign wiperOutput = output_q;
  assign calStart    = cal_q;
endmodule
`default_nettype wire

// [include/bcc_pkg.sv]
// types shared by the bias controller register bank
// assumes bcc_regs.svh supplies the numeric constants
package bcc_pkg;
  // shutdown controls as seen by the analog side
  typedef struct packed {
    logic globalPowerDown;
    logic referenceKeepOn;
    logic oscillatorStop;
    logic converter2PowerDown;
    logic converter1PowerDown;
  } bcc_shut_t;

  // hardware alarm output configuration
  typedef struct packed {
    logic forceProtectCh1;
    logic forceProtectCh2;
    logic alertPolaritySel;
    logic alertDriveSel;
    logic protectCh1Polarity;
    logic protectCh1Drive;
    logic protectCh2Polarity;
    logic protectCh2Drive;
  } bcc_alarm_t;

  // full reset sequencer
  typedef enum logic [1:0] {
    BCC_IDLE  = 2'b01,
    BCC_ARMED = 2'b10
  } bcc_rst_state_t;
endpackage

// [include/bcc_regs.svh]
// register offsets, field positions, reset values and timing counts for the bias controller
// assumes a 16-bit write word and an 8-bit register selector from the serial command decoder
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

`define BCC_ADDR_FINE_PT1    8'h01
`define BCC_ADDR_FINE_PT2    8'h02
`define BCC_ADDR_FINE_PL1    8'h03
`define BCC_ADDR_FINE_PL2    8'h04
`define BCC_ADDR_FINE_CO1    8'h05
`define BCC_ADDR_FINE_CO2    8'h06
`define BCC_ADDR_UPW1        8'h07
`define BCC_ADDR_UPW2        8'h08
`define BCC_ADDR_LOW1        8'h09
`define BCC_ADDR_LOW2        8'h0A
`define BCC_ADDR_LOAD        8'h0B
`define BCC_ADDR_ALARM       8'h0C
`define BCC_ADDR_SCAN        8'h0D
`define BCC_ADDR_CLEAR       8'h0E
`define BCC_ADDR_SHUT        8'h0F

`define BCC_LD_FINE_INPUT_PLAIN_CH2         5
`define BCC_LD_UPW2          4
`define BCC_LD_LOW2          3
`define BCC_LD_FINE_INPUT_PLAIN_CH1         2
`define BCC_LD_UPW1          1
`define BCC_LD_LOW1          0

`define BCC_CL_FIRE          9
`define BCC_CL_ARM           8
`define BCC_CL_FLUSH         6
`define BCC_CL_UPW2          5
`define BCC_CL_LOW2          4
`define BCC_CL_FINE_INPUT_PLAIN_CH1         3
`define BCC_CL_UPW1          2
`define BCC_CL_LOW1          1
`define BCC_CL_FINE_INPUT_PLAIN_CH2         0

`define BCC_SH_GLOBAL        7
`define BCC_SH_REF           3
`define BCC_SH_OSC           2
`define BCC_SH_CONV2         1
`define BCC_SH_CONV1         0

`define BCC_CAL_FLAG         15
`define BCC_ALARM_RST        8'h00
`define BCC_SCAN_RST         8'h00
`define BCC_SHUT_RST         5'h13
`define BCC_FINE_RST         10'h000
`define BCC_WIPER_RST        9'h100
`define BCC_CAL_PULSE_CYC    1

`endif

// [tb/bcc_config_regs_bench.sv]
// self-checking bench for the bias controller register bank
// assumes the host model drives all writes; one clock, async reset
`timescale 1ns/100ps
`default_nettype none
module bcc_config_regs_bench
  import bcc_pkg::*;
;
  logic        clk, arst_n, regWrite, cmdSeen;
  logic [7:0]  regSel, alarmReadback, upperWiper1, upperWiper2, lowerWiper1, lowerWiper2;
  logic [15:0] regData;
  logic [9:0]  fineOut1, fineOut2;
  logic        fineCorr1, fineCorr2, repeatScanEnable, scanWritten, resultQueueFlush;
  logic [3:0]  autocalStart;
  logic [6:0]  scanSelect;
  bcc_alarm_t  alarmCfg;
  bcc_shut_t   shutCtl;
  int          fails, testsRun;

  bcc_config_regs bcc_config_regs_i (.clk, .arst_n, .regWrite, .regSel, .regData,
    .cmdSeen, .alarmReadback, .fineOut1, .fineOut2, .fineCorr1, .fineCorr2,
    .upperWiper1, .upperWiper2, .lowerWiper1, .lowerWiper2, .autocalStart, .alarmCfg,
    .repeatScanEnable, .scanSelect, .scanWritten, .resultQueueFlush, .shutCtl);
  bcc_host_model bcc_host_model_i (.clk, .regWrite, .regSel, .regData, .cmdSeen);

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, fails);
  endtask

  // write and let the update land before looking
  task automatic w(input logic [7:0] s, input logic [15:0] d);
    bcc_host_model_i.wr(s, d);
    #1;
  endtask

  task automatic t_fine();
    w(8'h01, 16'hFFFF);
    check("fineOut1", fineOut1, 16'h03FF);
    w(8'h02, 16'hFE01);
    check("fineOut2", fineOut2, 16'h0201);
    w(8'h06, 16'h02AA);
    w(8'h04, 16'h0155);
    check("fineOut2", fineOut2, 16'h0201);
    w(8'h0B, 16'hFFE0);
    check("fineOut2", fineOut2, 16'h0155);
    check("fineCorr2", fineCorr2, 16'h0000);
    w(8'h05, 16'h00F0);
    w(8'h0B, 16'h0004);
    check("fineOut1", fineOut1, 16'h00F0);
    check("fineCorr1", fineCorr1, 16'h0001);
    done("fine");
  endtask

  task automatic t_wiper();
    w(8'h08, 16'h8055);
    w(8'h09, 16'h0033);
    w(8'h0B, 16'h0011);
    check("upperWiper2", upperWiper2, 16'h0055);
    check("lowerWiper1", lowerWiper1, 16'h0033);
    check("autocalStart", autocalStart, 16'h0004);
    @(posedge clk);
    #1;
    check("autocalStart", autocalStart, 16'h0000);
    check("fineOut1", fineOut1, 16'h00F0);
    // pending input with strobe bits only in the ignored field must not load
    w(8'h08, 16'h00AA);
    w(8'h0B, 16'hFFC0);
    check("upperWiper2", upperWiper2, 16'h0055);
    check("autocalStart", autocalStart, 16'h0000);
    w(8'h07, 16'h80A5);
    w(8'h0A, 16'h805A);
    w(8'h0B, 16'h000A);
    check("upperWiper1", upperWiper1, 16'h00A5);
    check("lowerWiper2", lowerWiper2, 16'h005A);
    check("autocalStart", autocalStart, 16'h0009);
    done("wiper");
  endtask

  task automatic t_clear();
    w(8'h0E, 16'h0000);
    check("upperWiper2", upperWiper2, 16'h0055);
    check("flush", resultQueueFlush, 16'h0000);
    w(8'h0E, 16'hFC3F);
    check("fineOut1", fineOut1, 16'h0000);
    check("fineOut2", fineOut2, 16'h0000);
    check("upperWiper2", upperWiper2, 16'h0000);
    check("lowerWiper1", lowerWiper1, 16'h0000);
    check("upperWiper1", upperWiper1, 16'h0000);
    check("lowerWiper2", lowerWiper2, 16'h0000);
    check("flush", resultQueueFlush, 16'h0000);
    w(8'h0B, 16'h003F);
    check("fineOut2", fineOut2, 16'h0000);
    check("autocalStart", autocalStart, 16'h000F);
    w(8'h0E, 16'h0040);
    check("flush", resultQueueFlush, 16'h0001);
    done("clear");
  endtask

  task automatic t_power();
    w(8'h01, 16'h0123);
    w(8'h0F, 16'h000C);
    check("shutCtl", shutCtl, 16'h0003);
    w(8'h0F, 16'h000C);
    check("shutCtl", shutCtl, 16'h000C);
    bcc_host_model_i.cmd();
    #1;
    check("shutCtl", shutCtl, 16'h0008);
    w(8'h0E, 16'h0200);
    check("fineOut1", fineOut1, 16'h0123);
    bcc_host_model_i.full_rst();
    #1;
    check("fineOut1", fineOut1, 16'h0000);
    check("shutCtl", shutCtl, 16'h0013);
    check("flush", resultQueueFlush, 16'h0001);
    bcc_host_model_i.wake(16'h0000);
    #1;
    check("shutCtl", shutCtl, 16'h0000);
    done("power");
  endtask

  task automatic t_cfg();
    logic [15:0] b;
    for (int i = 0; i < 8; i++) begin
      b = 16'h0001 << i;
      w(8'h0C, b | 16'hFF00);
      check("alarmReadback", alarmReadback, b);
      check("alarmCfg", alarmCfg, b);
      w(8'h0D, b | 16'hFF00);
      check("scan", {repeatScanEnable, scanSelect}, b);
      check("scanWritten", scanWritten, 16'h0001);
    end
    // unmapped selectors must leave everything alone
    w(8'h00, 16'hFFFF);
    w(8'h10, 16'hFFFF);
    check("alarmReadback", alarmReadback, 16'h0080);
    check("fineOut1", fineOut1, 16'h0000);
    done("cfg");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    fails    = 0;
    testsRun = 0;
    arst_n   = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check("shutCtl", shutCtl, 16'h0013);
    check("alarmReadback", alarmReadback, 16'h0000);
    check("fineOut1", fineOut1, 16'h0000);
    check("scan", {repeatScanEnable, scanSelect}, 16'h0000);
    done("por");
    t_fine();
    t_wiper();
    t_clear();
    t_power();
    t_cfg();
    give_verdict();
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire

// [tb/bcc_config_regs_sva.sv]
// port assertions for the bias controller register bank
// assumes one clock domain and the selector map of the register header
`timescale 1ns/100ps
`default_nettype none
module bcc_config_regs_sva
  import bcc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // serial writes
  input wire logic        regWrite,
  input wire logic [7:0]  regSel,
  input wire logic [15:0] regData,
  input wire logic        cmdSeen,
  // watched outputs
  input wire logic [7:0]  alarmReadback,
  input wire logic [9:0]  fineOut1,
  input wire logic [7:0]  upperWiper2,
  input wire logic [3:0]  autocalStart,
  input wire logic        repeatScanEnable,
  input wire logic [6:0]  scanSelect,
  input wire logic        scanWritten,
  input wire logic        resultQueueFlush,
  input wire bcc_shut_t   shutCtl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // clear-register write decode, shared by several checks
  logic wrClr;
  assign wrClr = regWrite && regSel == 8'h0E;

  chk_pt_fine: assert property (
    regWrite && regSel == 8'h01 |=> fineOut1 == $past(regData[9:0]))
    else $error("passthrough code not on fine output");
  chk_alarm_store: assert property (
    regWrite && regSel == 8'h0C |=> alarmReadback == $past(regData[7:0]))
    else $error("alarm config not stored");
  chk_scan_store: assert property (
    regWrite && regSel == 8'h0D |=>
      {repeatScanEnable, scanSelect} == $past(regData[7:0]) && scanWritten)
    else $error("scan setup not stored");
  chk_flush_pulse: assert property (
    wrClr && regData[6] |=> resultQueueFlush)
    else $error("flush pulse missing");
  chk_flush_cause: assert property (
    resultQueueFlush |-> $past(wrClr))
    else $error("flush without clear write");
  chk_clear_fine: assert property (
    wrClr && regData[3] |=> fineOut1 == 10'h000)
    else $error("fine clear ignored");
  chk_clear_wiper: assert property (
    wrClr && regData[5] |=> upperWiper2 == 8'h00)
    else $error("wiper clear ignored");
  // a strobe that stayed pending would move the output with no write
  chk_fine_hold: assert property (
    $changed(fineOut1) |-> $past(regWrite))
    else $error("fine output moved without a write");
  chk_cal_cause: assert property (
    autocalStart != 4'h0 |-> $past(regWrite && regSel == 8'h0B))
    else $error("autocal without load strobe");
  chk_osc_wake: assert property (
    cmdSeen && !(regWrite && regSel == 8'h0F) |=> !shutCtl.oscillatorStop)
    else $error("oscillator not restarted");
  chk_pd_first: assert property (
    regWrite && regSel == 8'h0F && shutCtl.globalPowerDown |=> $stable(shutCtl[3:0]))
    else $error("block bits changed under global power-down");

  // main scenarios
  cover property (wrClr && regData[9]);
  cover property (autocalStart != 4'h0);
  cover property (shutCtl.oscillatorStop && cmdSeen);
endmodule

bind bcc_config_regs bcc_config_regs_sva bcc_config_regs_sva_i (
  .clk, .arst_n, .regWrite, .regSel, .regData, .cmdSeen, .alarmReadback,
  .fineOut1, .upperWiper2, .autocalStart, .repeatScanEnable, .scanSelect,
  .scanWritten, .resultQueueFlush, .shutCtl
);
`default_nettype wire

// [tb/bcc_host_model.sv]
// host controller model: issues register writes and commands
// assumes the bench calls its tasks; one write per wr call, full_rst and wake issue two
`timescale 1ns/100ps
`default_nettype none
module bcc_host_model (
  // clock
  input  wire logic   clk,
  // serial decoder side
  output logic        regWrite,
  output logic [7:0]  regSel,
  output logic [15:0] regData,
  output logic        cmdSeen
);
  // idle levels at time zero
  initial begin
    regWrite = 1'b0;
    regSel   = 8'h00;
    regData  = 16'h0000;
    cmdSeen  = 1'b0;
  end

  // data is inverted once released so a stale word is never mistaken for valid
  task automatic wr(input logic [7:0] sel, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regSel   <= sel;
    regData  <= (sel == 8'h0D) ? (d & 16'hF0FF) : d;
    @(posedge clk);
    regWrite <= 1'b0;
    regData  <= ~regData;
  endtask

  // bare command with no register write
  task automatic cmd();
    @(posedge clk);
    cmdSeen <= 1'b1;
    @(posedge clk);
    cmdSeen <= 1'b0;
  endtask

  // arm then fire, nothing between
  task automatic full_rst();
    wr(8'h0E, 16'h0100);
    wr(8'h0E, 16'h0200);
  endtask

  // first write only drops global power-down, second sets the blocks
  task automatic wake(input logic [15:0] d);
    wr(8'h0F, 16'h0000);
    wr(8'h0F, d);
  endtask
endmodule
`default_nettype wire
